/* design/dcfc_pkg.sv */
package dcfc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG   = 8'h00;
    localparam logic [7:0] ADDR_ENABLED  = 8'h04;
    localparam logic [7:0] ADDR_INT_STAT = 8'h08;
    localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
    localparam logic [7:0] ADDR_XFER_CTL = 8'h10;

    // ------------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------------
    localparam int CFG_ENABLE_BIT  = 0;
    localparam int CFG_SRC_LSB     = 1;
    localparam int CFG_DST_LSB     = 6;
    localparam int CFG_FLOW_LSB    = 11;
    localparam int CFG_LOCK_BIT    = 16;
    localparam int CFG_ACTIVE_BIT  = 17;
    localparam int CFG_HALT_BIT    = 18;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK = 32'h0007_dbdf;

    // Interrupt status bits
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_ERR_BIT    = 1;
    localparam int IRQ_DRAIN_BIT  = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // Transfer control register bits
    localparam int XC_LAST_BIT = 0;

    // FIFO depth in words
    localparam int FIFO_DEPTH = 4;
    localparam logic [2:0] FIFO_FULL = 3'h4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FLOW_M2M_DMA  = 3'b000,
        FLOW_M2P_DMA  = 3'b001,
        FLOW_P2M_DMA  = 3'b010,
        FLOW_P2P_DMA  = 3'b011,
        FLOW_P2P_DST  = 3'b100,
        FLOW_M2P_PER  = 3'b101,
        FLOW_P2M_PER  = 3'b110,
        FLOW_P2P_SRC  = 3'b111
    } dcfc_flow_e;

    typedef enum logic [1:0] {
        CTRL_DMA  = 2'b00,
        CTRL_SRC  = 2'b01,
        CTRL_DST  = 2'b10
    } dcfc_ctrl_e;

    typedef struct packed {
        logic       src_is_periph;
        logic       dst_is_periph;
        dcfc_ctrl_e controller;
    } dcfc_flow_s;

    typedef struct packed {
        logic       halt;
        logic       lock;
        dcfc_flow_e flow;
        logic [3:0] dst_sel;
        logic [3:0] src_sel;
        logic       enable;
    } dcfc_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_BUSY = 2'b10,
        ST_STOP = 2'b11
    } dcfc_state_e;

endpackage

/* design/dcfc_flow_decode.sv */
`timescale 1ns/1ps
module dcfc_flow_decode (
    // Flow select in
    input  wire logic [2:0]          flow_transfer_select_i,
    // Decoded roles
    output dcfc_pkg::dcfc_flow_s     flow_o
);

    always_comb begin
        flow_o = '{src_is_periph: 1'b1, dst_is_periph: 1'b1,
                   controller: dcfc_pkg::CTRL_DMA};
        case (flow_transfer_select_i)
            3'b000: begin
                flow_o.src_is_periph = 1'b0;
                flow_o.dst_is_periph = 1'b0;
            end
            3'b001: flow_o.src_is_periph = 1'b0;
            3'b010: flow_o.dst_is_periph = 1'b0;
            3'b011: flow_o.controller = dcfc_pkg::CTRL_DMA;
            3'b100: flow_o.controller = dcfc_pkg::CTRL_DST;
            3'b101: begin
                flow_o.src_is_periph = 1'b0;
                flow_o.controller    = dcfc_pkg::CTRL_DST;
            end
            3'b110: begin
                flow_o.dst_is_periph = 1'b0;
                flow_o.controller    = dcfc_pkg::CTRL_SRC;
            end
            3'b111: flow_o.controller = dcfc_pkg::CTRL_SRC;
            default: flow_o.controller = dcfc_pkg::CTRL_DMA;
        endcase
    end

endmodule

/* design/dcfc_req_mux.sv */
`timescale 1ns/1ps
module dcfc_req_mux (
    // Selection
    input  wire logic [3:0]  sel_i,
    input  wire logic        use_i,
    // Request line pairs
    input  wire logic [15:0] single_i,
    input  wire logic [15:0] burst_i,
    // Selected pair
    output logic             single_o,
    output logic             burst_o
);

    assign single_o = use_i & single_i[sel_i];
    assign burst_o  = use_i & burst_i[sel_i];

endmodule

/* design/dcfc_channel.sv */
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Config bits 13:11 select both the flow controller and transfer type.
// - Codes 000 to 011 are mem-mem, mem-per, per-mem, per-per under DMA.
// - 100 per-per by dest, 101 mem-per by per, 110 per-mem by per, 111 by src.
// - Bits 9:6 pick the destination requester, ignored when dest is memory.
// - Bits 4:1 pick the source requester, ignored when source is memory.
// - Bits 10 and 5 are unused, read as zero here, and software writes zero.
// - Bit 0 enables the channel and reads back the live enable state.
// - The enable state also shows in the enabled channels summary register.
// - Clearing enable lets the bus beat finish, then stops and drops FIFO data.
// - The channel clears its own enable after the last descriptor or an error.
// - While halted, source peripheral requests are ignored and the FIFO drains.
// - The active flag is zero exactly when the FIFO holds no data.
// - Halt sits at bit 18 and the read-only active flag at bit 17.
// - Descriptor loads never overwrite the configuration register.
module dcfc_channel (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    // Peripheral requests
    input  wire logic [15:0] per_single_req_i,
    input  wire logic [15:0] per_burst_req_i,
    // Bus transfer engine
    input  wire logic        bus_busy_i,
    input  wire logic        bus_read_done_i,
    input  wire logic        bus_write_done_i,
    input  wire logic        bus_error_i,
    input  wire logic        desc_load_i,
    input  wire logic        desc_last_i,
    // Transfer qualifiers
    output logic             src_req_o,
    output logic             dst_req_o,
    output logic             read_go_o,
    output logic             write_go_o,
    output logic [1:0]       flow_ctrl_o,
    output logic             lock_o,
    output logic             fifo_active_o,
    output logic             chan_on_o,
    // Interrupt
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // Configuration and state
    // ------------------------------------------------------------------
    dcfc_pkg::dcfc_cfg_s   cfg;
    dcfc_pkg::dcfc_flow_s  flow;
    dcfc_pkg::dcfc_state_e state;
    dcfc_pkg::dcfc_state_e next_state;
    logic [2:0]            fifo_cnt;
    logic [2:0]            int_stat;
    logic [2:0]            int_mask;
    logic                  last_desc;
    logic                  src_sel_req;
    logic                  dst_sel_req;
    logic                  src_burst;
    logic                  dst_burst;
    logic                  fifo_in;
    logic                  fifo_out;
    logic                  wr_cfg;
    logic                  sw_disable;
    logic                  hw_stop;
    logic                  stop_now;
    logic                  drained_evt;
    logic                  active_q;
    logic [31:0]           cfg_word;

    assign wr_cfg = reg_wr_i && (reg_addr_i == dcfc_pkg::ADDR_CONFIG);
    assign sw_disable = wr_cfg && !reg_wdata_i[dcfc_pkg::CFG_ENABLE_BIT];
    assign hw_stop = bus_error_i
                   || (bus_write_done_i && last_desc
                       && fifo_cnt == 3'h1 && !fifo_in);

    // ------------------------------------------------------------------
    // Flow decode and request selection
    // ------------------------------------------------------------------
    dcfc_flow_decode u_flow (
        .flow_transfer_select_i (cfg.flow),
        .flow_o                 (flow)
    );

    dcfc_req_mux u_src_mux (
        .sel_i    (cfg.src_sel),
        .use_i    (flow.src_is_periph && cfg.enable && !cfg.halt),
        .single_i (per_single_req_i),
        .burst_i  (per_burst_req_i),
        .single_o (src_sel_req),
        .burst_o  (src_burst)
    );

    dcfc_req_mux u_dst_mux (
        .sel_i    (cfg.dst_sel),
        .use_i    (flow.dst_is_periph && cfg.enable),
        .single_i (per_single_req_i),
        .burst_i  (per_burst_req_i),
        .single_o (dst_sel_req),
        .burst_o  (dst_burst)
    );

    assign src_req_o   = src_sel_req | src_burst;
    assign dst_req_o   = dst_sel_req | dst_burst;
    assign flow_ctrl_o = flow.controller;
    assign lock_o      = cfg.lock;
    assign chan_on_o   = cfg.enable;

    // Memory sides are always ready; halted sources take no new reads
    assign read_go_o = cfg.enable && !cfg.halt
                     && (fifo_cnt != dcfc_pkg::FIFO_FULL)
                     && (flow.src_is_periph ? src_req_o : 1'b1);
    assign write_go_o = cfg.enable && (fifo_cnt != 3'h0)
                      && (flow.dst_is_periph ? dst_req_o : 1'b1);

    // ------------------------------------------------------------------
    // Channel state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        stop_now   = 1'b0;
        case (state)
            dcfc_pkg::ST_IDLE: begin
                // Enable may be cleared before the machine has left idle
                if (cfg.enable && sw_disable && bus_busy_i) begin
                    next_state = dcfc_pkg::ST_BUSY;
                end else if (cfg.enable && sw_disable) begin
                    stop_now   = 1'b1;
                end else if (cfg.enable) begin
                    next_state = dcfc_pkg::ST_RUN;
                end
            end
            dcfc_pkg::ST_RUN: begin
                if (hw_stop) begin
                    stop_now   = 1'b1;
                    next_state = dcfc_pkg::ST_IDLE;
                end else if (sw_disable && bus_busy_i) begin
                    next_state = dcfc_pkg::ST_BUSY;
                end else if (sw_disable) begin
                    stop_now   = 1'b1;
                    next_state = dcfc_pkg::ST_IDLE;
                end
            end
            dcfc_pkg::ST_BUSY: begin
                if (!bus_busy_i || bus_error_i) begin
                    next_state = dcfc_pkg::ST_STOP;
                end
            end
            dcfc_pkg::ST_STOP: begin
                stop_now   = 1'b1;
                next_state = dcfc_pkg::ST_IDLE;
            end
            default: next_state = dcfc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= dcfc_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg <= '0;
        end else begin
            if (wr_cfg) begin
                cfg.halt    <= reg_wdata_i[dcfc_pkg::CFG_HALT_BIT];
                cfg.lock    <= reg_wdata_i[dcfc_pkg::CFG_LOCK_BIT];
                cfg.flow    <= dcfc_pkg::dcfc_flow_e'(
                    reg_wdata_i[dcfc_pkg::CFG_FLOW_LSB +: 3]);
                cfg.dst_sel <= reg_wdata_i[dcfc_pkg::CFG_DST_LSB +: 4];
                cfg.src_sel <= reg_wdata_i[dcfc_pkg::CFG_SRC_LSB +: 4];
            end
            // Descriptor loads touch nothing here
            if (hw_stop && cfg.enable) begin
                cfg.enable <= 1'b0;
            end else if (wr_cfg && reg_wdata_i[dcfc_pkg::CFG_ENABLE_BIT]) begin
                cfg.enable <= 1'b1;
            end else if (stop_now) begin
                cfg.enable <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Last descriptor tracking
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_desc <= 1'b0;
        end else if (desc_load_i) begin
            last_desc <= desc_last_i;
        end else if (!cfg.enable) begin
            last_desc <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // FIFO occupancy
    // ------------------------------------------------------------------
    assign fifo_in  = bus_read_done_i && cfg.enable
                    && (fifo_cnt != dcfc_pkg::FIFO_FULL);
    assign fifo_out = bus_write_done_i && (fifo_cnt != 3'h0);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fifo_cnt <= 3'h0;
        end else if (stop_now) begin
            fifo_cnt <= 3'h0;
        end else if (fifo_in && !fifo_out) begin
            fifo_cnt <= fifo_cnt + 3'h1;
        end else if (fifo_out && !fifo_in) begin
            fifo_cnt <= fifo_cnt - 3'h1;
        end
    end

    assign fifo_active_o = (fifo_cnt != 3'h0);

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_q <= 1'b0;
        end else begin
            active_q <= fifo_active_o;
        end
    end

    assign drained_evt = active_q && !fifo_active_o && cfg.halt;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_stat <= 3'h0;
        end else begin
            if (reg_rd_i && reg_addr_i == dcfc_pkg::ADDR_INT_STAT) begin
                int_stat <= 3'h0;
            end
            // Events win over the read clear
            if (hw_stop && !bus_error_i && cfg.enable) begin
                int_stat[dcfc_pkg::IRQ_DONE_BIT] <= 1'b1;
            end
            if (bus_error_i && cfg.enable) begin
                int_stat[dcfc_pkg::IRQ_ERR_BIT] <= 1'b1;
            end
            if (drained_evt) begin
                int_stat[dcfc_pkg::IRQ_DRAIN_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_mask <= dcfc_pkg::IRQ_MASK_RESET;
        end else if (reg_wr_i && reg_addr_i == dcfc_pkg::ADDR_INT_MASK) begin
            int_mask <= reg_wdata_i[2:0];
        end
    end

    assign irq_o = |(int_stat & int_mask);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        cfg_word = 32'h0; // Bits 10, 5 and 31:19 read zero
        cfg_word[dcfc_pkg::CFG_HALT_BIT]   = cfg.halt;
        cfg_word[dcfc_pkg::CFG_ACTIVE_BIT] = fifo_active_o;
        cfg_word[dcfc_pkg::CFG_LOCK_BIT]   = cfg.lock;
        cfg_word[dcfc_pkg::CFG_FLOW_LSB +: 3] = cfg.flow;
        cfg_word[dcfc_pkg::CFG_DST_LSB +: 4]  = cfg.dst_sel;
        cfg_word[dcfc_pkg::CFG_SRC_LSB +: 4]  = cfg.src_sel;
        cfg_word[dcfc_pkg::CFG_ENABLE_BIT]    = cfg.enable;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 32'h0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                dcfc_pkg::ADDR_CONFIG:   reg_rdata_o <= cfg_word;
                dcfc_pkg::ADDR_ENABLED:  reg_rdata_o <= {31'h0, cfg.enable};
                dcfc_pkg::ADDR_INT_STAT: reg_rdata_o <= {29'h0, int_stat};
                dcfc_pkg::ADDR_INT_MASK: reg_rdata_o <= {29'h0, int_mask};
                dcfc_pkg::ADDR_XFER_CTL: reg_rdata_o <= {30'h0, state};
                default:                 reg_rdata_o <= 32'h0;
            endcase
        end else begin
            reg_rdata_o <= 32'h0;
        end
    end

endmodule

/* sim/dcfc_channel_chk.sv */
`timescale 1ns/1ps
module dcfc_channel_chk (
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rst_b_i,
    // Register port
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Engine and status
    input wire logic        bus_busy_i,
    input wire logic        bus_read_done_i,
    input wire logic        bus_write_done_i,
    input wire logic        bus_error_i,
    input wire logic        desc_load_i,
    input wire logic [1:0]  flow_ctrl_o,
    input wire logic        fifo_active_o,
    input wire logic        chan_on_o
);
    // Controller code of each flow select, two bits apiece
    localparam logic [15:0] CTRL_TBL = 16'h5a00;
    logic       cfg_wr;
    logic       cfg_rd;
    logic [2:0] flow_q;
    assign cfg_wr = reg_wr_i && reg_addr_i == dcfc_pkg::ADDR_CONFIG;
    assign cfg_rd = reg_rd_i && reg_addr_i == dcfc_pkg::ADDR_CONFIG;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flow_q <= 3'h0;
        end else if (cfg_wr) begin
            flow_q <= reg_wdata_i[13:11];
        end
    end
    default clocking dcfc_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    AST_FLOW_MAP: assert property (
        flow_ctrl_o == CTRL_TBL[{flow_q, 1'b0} +: 2])
        else $error("flow controller code mismatch");
    AST_CFG_READ: assert property (
        cfg_rd |=> reg_rdata_o[0] == $past(chan_on_o)
            && reg_rdata_o[17] == $past(fifo_active_o)
            && reg_rdata_o[10] == 1'b0 && reg_rdata_o[5] == 1'b0)
        else $error("config readback mismatch");
    AST_SUMMARY: assert property (
        reg_rd_i && reg_addr_i == dcfc_pkg::ADDR_ENABLED
            |=> reg_rdata_o[0] == $past(chan_on_o))
        else $error("summary bit differs from channel state");
    AST_ON_WRITE: assert property (
        cfg_wr && reg_wdata_i[0] && !bus_error_i && !bus_write_done_i
            |=> chan_on_o)
        else $error("enable write did not start channel");
    AST_OFF_IDLE: assert property (
        cfg_wr && !reg_wdata_i[0] && !bus_busy_i
            |=> !chan_on_o && !fifo_active_o)
        else $error("idle disable did not stop and flush");
    AST_BUSY_HOLD: assert property (
        chan_on_o && bus_busy_i && !bus_error_i && !bus_write_done_i
            |=> chan_on_o)
        else $error("channel stopped during a bus beat");
    AST_ERR_STOP: assert property (
        bus_error_i |=> !chan_on_o)
        else $error("channel still on after error");
    AST_FILL: assert property (
        bus_read_done_i && chan_on_o && !bus_error_i && !cfg_wr
            |=> fifo_active_o)
        else $error("active flag low with data in fifo");
    AST_DESC_KEEP: assert property (
        desc_load_i && !cfg_wr |=> $stable(flow_ctrl_o))
        else $error("descriptor load changed configuration");
    AST_OFF_FLUSH: assert property (
        $fell(chan_on_o) && !$past(bus_error_i) |-> !fifo_active_o)
        else $error("fifo data kept after channel stop");

    COV_ENABLE: cover property (cfg_wr && reg_wdata_i[0]);
    COV_BUSY_STOP: cover property (chan_on_o && bus_busy_i ##1 !bus_busy_i);
    COV_DRAIN: cover property (fifo_active_o ##1 !fifo_active_o);
endmodule

bind dcfc_channel dcfc_channel_chk chk_u (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .bus_busy_i(bus_busy_i),
    .bus_read_done_i(bus_read_done_i), .bus_error_i(bus_error_i),
    .bus_write_done_i(bus_write_done_i), .desc_load_i(desc_load_i),
    .flow_ctrl_o(flow_ctrl_o), .fifo_active_o(fifo_active_o),
    .chan_on_o(chan_on_o)
);

/* sim/dcfc_periph_model.sv */
`timescale 1ns/1ps
module dcfc_periph_model (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    // Request command
    input  wire logic [3:0]  idx_i,
    input  wire logic        req_i,
    input  wire logic        burst_i,
    // Request line pairs
    output logic      [15:0] single_o,
    output logic      [15:0] burst_o
);
    // Only the commanded peripheral raises a line, one cycle later
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            single_o <= 16'h0;
            burst_o  <= 16'h0;
        end else begin
            single_o <= (req_i && !burst_i) ? 16'h1 << idx_i : 16'h0;
            burst_o  <= (req_i && burst_i) ? 16'h1 << idx_i : 16'h0;
        end
    end
endmodule

/* sim/dma_channel_config_flow_control_bench.sv */
`timescale 1ns/1ps
module dma_channel_config_flow_control_bench;
    localparam logic [7:0]  A_CFG = dcfc_pkg::ADDR_CONFIG;
    localparam logic [7:0]  A_EN = dcfc_pkg::ADDR_ENABLED;
    localparam logic [7:0]  A_ST = dcfc_pkg::ADDR_INT_STAT;
    localparam logic [7:0]  A_MSK = dcfc_pkg::ADDR_INT_MASK;
    // Peripheral side per flow select, and controller codes
    localparam logic [7:0]  SRC_P = 8'hdc;
    localparam logic [7:0]  DST_P = 8'hba;
    localparam logic [15:0] CTRL_TBL = 16'h5a00;
    logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        busy = 1'b0, rdone = 1'b0, wdone = 1'b0, err = 1'b0;
    logic        dload = 1'b0, dlast = 1'b0, pm_req = 1'b0, pm_burst = 1'b0;
    logic [3:0]  pm_idx = 4'h0;
    logic [15:0] single, burst;
    logic        src_req, dst_req, read_go, write_go, fifo_act, chan_on, irq;
    logic [1:0]  flow_ctrl;
    logic        lock;
    int          miscompares = 0, num_checks = 0, cyc = 0;

    always #25 clk = ~clk;

    dcfc_channel dut_u (
        .sys_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(rdata), .per_single_req_i(single),
        .per_burst_req_i(burst), .bus_busy_i(busy),
        .bus_read_done_i(rdone), .bus_write_done_i(wdone),
        .bus_error_i(err), .desc_load_i(dload), .desc_last_i(dlast),
        .src_req_o(src_req), .dst_req_o(dst_req), .read_go_o(read_go),
        .write_go_o(write_go), .flow_ctrl_o(flow_ctrl), .lock_o(lock),
        .fifo_active_o(fifo_act), .chan_on_o(chan_on), .irq_o(irq)
    );
    dcfc_periph_model pm_u (
        .sys_clk_i(clk), .rst_b_i(rst_b), .idx_i(pm_idx), .req_i(pm_req),
        .burst_i(pm_burst), .single_o(single), .burst_o(burst)
    );

    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            $display("timeout after %0d cycles", cyc);
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic read_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr   <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // Pulse order: read done, write done, error, descriptor load
    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        {rdone, wdone, err, dload} <= m;
        @(posedge clk);
        {rdone, wdone, err, dload} <= 4'h0;
        #1;
    endtask
    task automatic request(input logic [3:0] i, input logic b, r);
        @(posedge clk);
        pm_idx   <= i;
        pm_burst <= b;
        pm_req   <= r;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        read_reg(A_CFG, dcfc_pkg::CFG_RESET);
        read_reg(A_EN, 32'h0);
        read_reg(8'h20, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_flow();
        logic [31:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {18'h0, 3'(i), 11'h147};
            write_reg(A_CFG, v);
            request(4'h3, 1'b0, 1'b1);
            chk(src_req, SRC_P[i]);
            chk(dst_req, 1'b0);
            request(4'h5, 1'b1, 1'b1);
            chk(dst_req, DST_P[i]);
            chk(src_req, 1'b0);
            chk(flow_ctrl, CTRL_TBL[2*i +: 2]);
            read_reg(A_CFG, v);
        end
        request(4'h0, 1'b0, 1'b0);
        write_reg(A_CFG, 32'h0);
        $display("flow select test done");
    endtask
    task automatic t_disable();
        write_reg(A_CFG, 32'h1);
        pulse(4'h8);
        pulse(4'h8);
        chk(fifo_act, 1'b1);
        read_reg(A_CFG, 32'h0002_0001);
        @(posedge clk);
        busy <= 1'b1;
        write_reg(A_CFG, 32'h0);
        chk(chan_on, 1'b1);
        read_reg(dcfc_pkg::ADDR_XFER_CTL, 32'h2);
        @(posedge clk);
        busy <= 1'b0;
        #1;
        for (int n = 0; n < 4 && chan_on === 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(chan_on, 1'b0);
        chk(fifo_act, 1'b0);
        read_reg(A_EN, 32'h0);
        $display("busy disable test done");
    endtask
    task automatic t_halt();
        write_reg(A_MSK, 32'h7);
        read_reg(A_MSK, 32'h7);
        write_reg(A_CFG, 32'h0000_1005);
        request(4'h2, 1'b0, 1'b1);
        chk(src_req, 1'b1);
        pulse(4'h8);
        pulse(4'h8);
        write_reg(A_CFG, 32'h0004_1005);
        chk(src_req, 1'b0);
        chk(read_go, 1'b0);
        chk(write_go, 1'b1);
        read_reg(A_CFG, 32'h0006_1005);
        pulse(4'h4);
        pulse(4'h4);
        chk(fifo_act, 1'b0);
        read_reg(A_CFG, 32'h0004_1005);
        chk(irq, 1'b1);
        read_reg(A_ST, 32'h4);
        chk(irq, 1'b0);
        write_reg(A_CFG, 32'h0);
        chk(chan_on, 1'b0);
        request(4'h0, 1'b0, 1'b0);
        $display("halt drain test done");
    endtask
    task automatic t_selfclr();
        write_reg(A_CFG, 32'h1);
        pulse(4'h2);
        chk(chan_on, 1'b0);
        chk(irq, 1'b1);
        read_reg(A_ST, 32'h2);
        write_reg(A_CFG, 32'h0001_0001);
        read_reg(A_EN, 32'h1);
        @(posedge clk);
        dlast <= 1'b1;
        pulse(4'h8);
        pulse(4'h1);
        read_reg(A_CFG, 32'h0003_0001);
        chk(lock, 1'b1);
        pulse(4'h4);
        chk(chan_on, 1'b0);
        read_reg(A_ST, 32'h1);
        read_reg(A_EN, 32'h0);
        @(posedge clk);
        dlast <= 1'b0;
        $display("self clear test done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_flow();
        t_disable();
        t_halt();
        t_selfclr();
        final_report();
    end
endmodule
